// >>> logic/lsc_slot_regs.sv
// Register bank and slot logic for regulator_six sleep and regulator_seven control.
// Assumes an APB master, a sequencer giving slot strobes, and synchronous inputs.
`timescale 1ns/1ps
module lsc_slot_regs
  import lsc_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic RESETN_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [LSC_ADDR_W-1:0] PADDR_IN,
  input wire logic [LSC_DATA_W-1:0] PWDATA_IN,
  input wire logic [3:0] PSTRB_IN,
  output logic PREADY_OUT,
  output logic [LSC_DATA_W-1:0] PRDATA_OUT,
  output logic PSLVERR_OUT,
  input wire logic SEQ_SLEEP_IN,
  input wire logic SEQ_SLOT_STROBE_IN,
  input wire logic [2:0] SEQ_SLOT_IN,
  input wire logic SIX_HW_ASSIGNED_IN,
  input wire logic HW_ENABLE1_IN,
  input wire logic HW_ENABLE2_IN,
  input wire logic HWCTL1_IN,
  input wire logic HWCTL2_IN,
  input wire logic [4:0] SEVEN_SLEEP_VOLTAGE_IN,
  input wire logic SEVEN_UNDERVOLT_IN,
  output logic IRQ_OUT,
  output logic SIX_SLEEP_DISABLE_OUT,
  output logic SIX_SLEEP_STATE_OUT,
  output logic [4:0] SIX_SLEEP_VOLTAGE_OUT,
  output logic SIX_SLEEP_LOWPOWER_OUT,
  output logic SEVEN_ENABLE_OUT,
  output logic [4:0] SEVEN_VOLTAGE_OUT,
  output logic SEVEN_LOWPOWER_OUT,
  output logic SEVEN_FLOAT_OUT,
  output logic SEVEN_SWITCH_OUT,
  output logic SEVEN_HWCTL_ACTIVE_OUT,
  output logic SEVEN_UV_SHUTDOWN_OUT,
  output logic SYS_RESET_REQ_OUT
);
  typedef enum logic [1:0] {LSC_AWAKE, LSC_WAIT, LSC_ASLEEP, LSC_DISABLED} lsc_six_state_t;

  logic [15:0] six_sleep;
  logic [15:0] seven_ctl;
  logic [15:0] seven_on;
  logic [LSC_IRQ_W-1:0] irq_status;
  logic [LSC_IRQ_W-1:0] irq_mask;
  logic uv_prev;
  logic seven_slot_on;
  lsc_six_state_t six_state;
  lsc_six_state_t next_six_state;

  lsc_ctl_if ctl ();

  lsc_seven_eval u_eval (
    .ctl(ctl)
  );

  assign ctl.seven_ctl = seven_ctl;
  assign ctl.seven_on = seven_on;
  assign ctl.seven_sleep_voltage = SEVEN_SLEEP_VOLTAGE_IN;
  assign ctl.hwctl1 = HWCTL1_IN;
  assign ctl.hwctl2 = HWCTL2_IN;

  // Bus decode.
  wire setup = PSEL_IN && !PENABLE_IN;
  wire access = PSEL_IN && PENABLE_IN && PREADY_OUT;
  wire hit_six = (PADDR_IN == lsc_addr(LSC_IDX_SIX_SLEEP));
  wire hit_ctl = (PADDR_IN == lsc_addr(LSC_IDX_SEVEN_CTL));
  wire hit_on = (PADDR_IN == lsc_addr(LSC_IDX_SEVEN_ON));
  wire hit_ists = (PADDR_IN == lsc_addr(LSC_IDX_IRQ_STATUS));
  wire hit_imsk = (PADDR_IN == lsc_addr(LSC_IDX_IRQ_MASK));
  wire hit_state = (PADDR_IN == lsc_addr(LSC_IDX_STATE));
  wire mapped = hit_six || hit_ctl || hit_on || hit_ists || hit_imsk || hit_state;
  wire wr = access && PWRITE_IN && mapped;
  wire [15:0] lane_mask = {{8{PSTRB_IN[1]}}, {8{PSTRB_IN[0]}}};
  wire [15:0] wdata = PWDATA_IN[15:0];

  wire [15:0] state_word = {10'h000, SEVEN_UV_SHUTDOWN_OUT, SEVEN_HWCTL_ACTIVE_OUT,
    SEVEN_ENABLE_OUT, SIX_SLEEP_DISABLE_OUT, SIX_SLEEP_STATE_OUT, seven_slot_on};
  wire [15:0] read_word;
  assign read_word = hit_six ? six_sleep :
    hit_ctl ? seven_ctl :
    hit_on ? seven_on :
    hit_ists ? {13'h0000, irq_status} :
    hit_imsk ? {13'h0000, irq_mask} :
    hit_state ? state_word : 16'h0000;

  function automatic logic [15:0] lsc_merge(input logic [15:0] old, input logic [15:0] wmask,
      input logic [15:0] lanes, input logic [15:0] data);
    logic [15:0] sel;
    sel = wmask & lanes;
    return (old & ~sel) | (data & sel);
  endfunction : lsc_merge

  // Regulator_six sleep decode.
  wire [2:0] six_code = six_sleep[LSC_SLOT_LO +: 3];
  wire six_slot_hit = SEQ_SLOT_STROBE_IN && (SEQ_SLOT_IN == lsc_sleep_slot(six_code));
  wire six_goes_off = lsc_is_disable(six_code) && !SIX_HW_ASSIGNED_IN;

  always_comb begin
    next_six_state = six_state;
    case (six_state)
      LSC_AWAKE: begin
        if (SEQ_SLEEP_IN) begin
          next_six_state = LSC_WAIT;
        end
      end
      LSC_WAIT: begin
        if (!SEQ_SLEEP_IN) begin
          next_six_state = LSC_AWAKE;
        end else if (six_slot_hit && six_goes_off) begin
          next_six_state = LSC_DISABLED;
        end else if (six_slot_hit) begin
          next_six_state = LSC_ASLEEP;
        end
      end
      default: begin
        if (!SEQ_SLEEP_IN) begin
          next_six_state = LSC_AWAKE;
        end
      end
    endcase
  end

  // Regulator_seven enable decode.
  wire [2:0] seven_code = seven_on[LSC_SLOT_LO +: 3];
  wire seven_slot_hit = SEQ_SLOT_STROBE_IN && !SEQ_SLEEP_IN && (SEQ_SLOT_IN == seven_code);
  wire next_seven_slot_on = SEQ_SLEEP_IN ? 1'b0 :
    (lsc_is_disable(seven_code) && (seven_slot_on || seven_slot_hit));
  wire seven_requested = (seven_code == LSC_SLOT_HW1) ? HW_ENABLE1_IN :
    (seven_code == LSC_SLOT_HW2) ? HW_ENABLE2_IN :
    next_seven_slot_on;

  // Undervolt handling.
  wire uv_event = SEVEN_UNDERVOLT_IN && !uv_prev;
  wire lsc_uv_t uv_act = lsc_uv_t'(seven_ctl[LSC_UVA_LO +: 2]);
  wire uv_clear = wr && hit_ists && PSTRB_IN[0] && PWDATA_IN[LSC_IRQ_UV];
  wire next_uv_shut = (uv_event && uv_act == LSC_UV_SHUT_REG) ||
    (SEVEN_UV_SHUTDOWN_OUT && !uv_clear);

  wire [LSC_IRQ_W-1:0] irq_set;
  assign irq_set[LSC_IRQ_UV] = uv_event;
  assign irq_set[LSC_IRQ_SIX_DIS] = (next_six_state == LSC_DISABLED) && (six_state != LSC_DISABLED);
  assign irq_set[LSC_IRQ_SIX_SLP] = (next_six_state == LSC_ASLEEP) && (six_state != LSC_ASLEEP);
  wire [LSC_IRQ_W-1:0] irq_clr = (wr && hit_ists && PSTRB_IN[0]) ?
    PWDATA_IN[LSC_IRQ_W-1:0] : '0;
  wire [LSC_IRQ_W-1:0] next_irq_status = irq_set | (irq_status & ~irq_clr);
  wire [LSC_IRQ_W-1:0] next_irq_mask = (wr && hit_imsk && PSTRB_IN[0]) ?
    PWDATA_IN[LSC_IRQ_W-1:0] : irq_mask;

  // Bus answer: data and error are prepared in the setup cycle, ready in the access cycle.
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      PREADY_OUT <= 1'b0;
      PRDATA_OUT <= '0;
      PSLVERR_OUT <= 1'b0;
    end else begin
      PREADY_OUT <= setup;
      PSLVERR_OUT <= setup && !mapped;
      if (setup) begin
        PRDATA_OUT <= {16'h0000, read_word};
      end
    end
  end

  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      six_sleep <= LSC_RST_SIX_SLEEP;
      seven_ctl <= LSC_RST_SEVEN_CTL;
      seven_on <= LSC_RST_SEVEN_ON;
    end else if (wr) begin
      if (hit_six) begin
        six_sleep <= lsc_merge(six_sleep, LSC_WMASK_SLOT_REG, lane_mask, wdata);
      end else if (hit_ctl) begin
        seven_ctl <= lsc_merge(seven_ctl, LSC_WMASK_SEVEN_CTL, lane_mask, wdata);
      end else if (hit_on) begin
        seven_on <= lsc_merge(seven_on, LSC_WMASK_SLOT_REG, lane_mask, wdata);
      end
    end
  end

  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      irq_status <= '0;
      irq_mask <= '0;
      IRQ_OUT <= 1'b0;
      uv_prev <= 1'b0;
      SEVEN_UV_SHUTDOWN_OUT <= 1'b0;
      SYS_RESET_REQ_OUT <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      IRQ_OUT <= |(next_irq_status & next_irq_mask);
      uv_prev <= SEVEN_UNDERVOLT_IN;
      SEVEN_UV_SHUTDOWN_OUT <= next_uv_shut;
      SYS_RESET_REQ_OUT <= uv_event && (uv_act == LSC_UV_SHUT_SYS);
    end
  end

  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      six_state <= LSC_AWAKE;
      SIX_SLEEP_DISABLE_OUT <= 1'b0;
      SIX_SLEEP_STATE_OUT <= 1'b0;
      SIX_SLEEP_VOLTAGE_OUT <= '0;
      SIX_SLEEP_LOWPOWER_OUT <= 1'b1;
    end else begin
      six_state <= next_six_state;
      SIX_SLEEP_DISABLE_OUT <= (next_six_state == LSC_DISABLED);
      SIX_SLEEP_STATE_OUT <= (next_six_state == LSC_ASLEEP);
      SIX_SLEEP_VOLTAGE_OUT <= six_sleep[4:0];
      SIX_SLEEP_LOWPOWER_OUT <= six_sleep[LSC_MODE_BIT];
    end
  end

  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      seven_slot_on <= 1'b0;
      SEVEN_ENABLE_OUT <= 1'b0;
      SEVEN_VOLTAGE_OUT <= '0;
      SEVEN_LOWPOWER_OUT <= 1'b0;
      SEVEN_FLOAT_OUT <= 1'b0;
      SEVEN_SWITCH_OUT <= 1'b0;
      SEVEN_HWCTL_ACTIVE_OUT <= 1'b0;
    end else begin
      seven_slot_on <= next_seven_slot_on;
      SEVEN_ENABLE_OUT <= seven_requested && !ctl.eff_off && !next_uv_shut;
      SEVEN_VOLTAGE_OUT <= ctl.eff_voltage;
      SEVEN_LOWPOWER_OUT <= ctl.eff_lowpower;
      SEVEN_FLOAT_OUT <= seven_ctl[LSC_FLT_BIT];
      SEVEN_SWITCH_OUT <= seven_ctl[LSC_SWI_BIT];
      SEVEN_HWCTL_ACTIVE_OUT <= ctl.hwctl_active;
    end
  end

  default clocking lsc_cb @(posedge CLK_IN);
  endclocking
  default disable iff (!RESETN_IN);

  property p_six_disable;
    (six_state == LSC_WAIT) && SEQ_SLEEP_IN && six_slot_hit && six_goes_off
      |=> SIX_SLEEP_DISABLE_OUT && !SIX_SLEEP_STATE_OUT ##1 (SIX_SLEEP_DISABLE_OUT == $past(SEQ_SLEEP_IN));
  endproperty
  a_six_disable: assert property (p_six_disable) else $error("six not disabled in slot");

  property p_six_transition;
    (six_state == LSC_WAIT) && SEQ_SLEEP_IN && SEQ_SLOT_STROBE_IN && !lsc_is_disable(six_code)
      && (SEQ_SLOT_IN == lsc_sleep_slot(six_code)) |=> SIX_SLEEP_STATE_OUT;
  endproperty
  a_six_transition: assert property (p_six_transition) else $error("six sleep missed");

  property p_six_hw_sleep;
    (six_state == LSC_WAIT) && SEQ_SLEEP_IN && six_slot_hit && SIX_HW_ASSIGNED_IN
      |=> SIX_SLEEP_STATE_OUT && !SIX_SLEEP_DISABLE_OUT;
  endproperty
  a_six_hw_sleep: assert property (p_six_hw_sleep) else $error("six hw sleep wrong");

  property p_six_mode;
    $changed(six_sleep[LSC_MODE_BIT]) |=> SIX_SLEEP_LOWPOWER_OUT == $past(six_sleep[LSC_MODE_BIT]);
  endproperty
  a_six_mode: assert property (p_six_mode) else $error("six sleep mode not followed");

  property p_six_voltage;
    wr && hit_six && (&PSTRB_IN[1:0]) |=> ##1 SIX_SLEEP_VOLTAGE_OUT == $past(PWDATA_IN[4:0], 2);
  endproperty
  a_six_voltage: assert property (p_six_voltage) else $error("six sleep voltage lost");

  property p_uv_sysreset;
    uv_event && (uv_act == LSC_UV_SHUT_SYS) |=> SYS_RESET_REQ_OUT ##1 !SYS_RESET_REQ_OUT;
  endproperty
  a_uv_sysreset: assert property (p_uv_sysreset) else $error("system reset not pulsed");

  property p_uv_irq;
    $rose(SEVEN_UNDERVOLT_IN)
      |=> irq_status[LSC_IRQ_UV] && (IRQ_OUT == (|(irq_status & irq_mask)));
  endproperty
  a_uv_irq: assert property (p_uv_irq) else $error("undervolt interrupt missing");

  property p_hw_active;
    (seven_ctl[LSC_SRC_LO +: 2] == 2'h3) && (HWCTL1_IN || HWCTL2_IN) |=> SEVEN_HWCTL_ACTIVE_OUT;
  endproperty
  a_hw_active: assert property (p_hw_active) else $error("either-input control ignored");

  property p_hw_off;
    ctl.hwctl_active && (seven_ctl[LSC_HMODE_LO +: 2] == 2'h1) |=> !SEVEN_ENABLE_OUT;
  endproperty
  a_hw_off: assert property (p_hw_off) else $error("seven on under off mode");

  property p_never_on;
    (seven_code == 3'h0) [*2] |=> !SEVEN_ENABLE_OUT;
  endproperty
  a_never_on: assert property (p_never_on) else $error("seven enabled with code 000");

  property p_on_mode;
    !ctl.hwctl_active |=> SEVEN_LOWPOWER_OUT == $past(seven_on[LSC_MODE_BIT]);
  endproperty
  a_on_mode: assert property (p_on_mode) else $error("seven on mode not applied");

  property p_uv_shutdown;
    uv_event && (uv_act == LSC_UV_SHUT_REG) |=> SEVEN_UV_SHUTDOWN_OUT && !SEVEN_ENABLE_OUT;
  endproperty
  a_uv_shutdown: assert property (p_uv_shutdown) else $error("uv shutdown missed");

  property p_uv_ignore;
    uv_event && (uv_act inside {LSC_UV_IGNORE, LSC_UV_RSVD})
      |=> !SYS_RESET_REQ_OUT && !$rose(SEVEN_UV_SHUTDOWN_OUT);
  endproperty
  a_uv_ignore: assert property (p_uv_ignore) else $error("ignored uv acted");

  property p_hw_voltage;
    ctl.hwctl_active && seven_ctl[LSC_HVSEL_BIT]
      |=> SEVEN_VOLTAGE_OUT == $past(SEVEN_SLEEP_VOLTAGE_IN);
  endproperty
  a_hw_voltage: assert property (p_hw_voltage) else $error("hw voltage wrong");

  property p_on_voltage;
    !ctl.hwctl_active |=> SEVEN_VOLTAGE_OUT == $past(seven_on[4:0]);
  endproperty
  a_on_voltage: assert property (p_on_voltage) else $error("on voltage wrong");

  property p_hw_lowpower;
    ctl.hwctl_active && !seven_ctl[LSC_HMODE_LO] |=> SEVEN_LOWPOWER_OUT;
  endproperty
  a_hw_lowpower: assert property (p_hw_lowpower) else $error("hw low power missed");

  property p_hw_enable;
    (seven_code == LSC_SLOT_HW1) && !ctl.eff_off && !next_uv_shut
      |=> SEVEN_ENABLE_OUT == $past(HW_ENABLE1_IN);
  endproperty
  a_hw_enable: assert property (p_hw_enable) else $error("hw enable not followed");

  property p_seven_float;
    1'b1 |=> (SEVEN_FLOAT_OUT == $past(seven_ctl[LSC_FLT_BIT]))
      && (SEVEN_SWITCH_OUT == $past(seven_ctl[LSC_SWI_BIT]));
  endproperty
  a_seven_float: assert property (p_seven_float) else $error("float or switch lost");

  c_six_disabled: cover property (SIX_SLEEP_DISABLE_OUT);
  c_six_asleep: cover property (SIX_SLEEP_STATE_OUT);
  c_seven_hw: cover property (SEVEN_HWCTL_ACTIVE_OUT && SEVEN_ENABLE_OUT);
  c_uv_irq: cover property (IRQ_OUT && SEVEN_UV_SHUTDOWN_OUT);
  c_seven_slot: cover property (seven_slot_on && SEVEN_ENABLE_OUT);
endmodule : lsc_slot_regs

// >>> logic/lsc_pkg.sv
// Constants, types and decode functions for the regulator slot control register bank.
// Assumes one clock domain and an APB master with 32-bit data on the register side.
// Behaviour
// - Sleep slot codes 001 to 101 of regulator_six disable it in timeslot 5, 4, 3, 2 and 1.
// - Sleep slot codes 000, 110 and 111 move regulator_six to sleep settings in slot 5, 3, 1.
// - With regulator_six on a hardware enable, codes 001 to 101 pick the sleep-entry slot.
// - Bit 8 of the regulator_six sleep register picks low power sleep mode and resets to 1.
// - Bits 4:0 of the regulator_six sleep register hold its sleep voltage code, reset zero.
// - Undervolt action of regulator_seven: 00 ignore, 01 shut regulator, 10 reset system.
// - Every undervolt event of regulator_seven raises an interrupt whatever the action.
// - Hardware control source of regulator_seven: none, input 1, input 2, or either.
// - Under hardware control regulator_seven takes on-voltage (0) or sleep-voltage (1).
// - Hardware control mode: 00 low power, 01 off, 10 low power, 11 on-mode; resets to 10.
// - Bit 7 floats the disabled output of regulator_seven and bit 6 selects switch mode.
// - On-slot of regulator_seven: 000 never, 001-101 slots 1-5, 110/111 hardware enable 1/2.
// - Bit 8 of the regulator_seven on register picks low power on mode and resets to 0.
// - Bits 4:0 of the regulator_seven on register hold its on-voltage code.
package lsc_pkg;
  localparam int LSC_DATA_W = 32;
  localparam int LSC_ADDR_W = 18;
  localparam int LSC_IRQ_W = 3;
  // Register indices; the byte address is four times the index.
  localparam logic [15:0] LSC_IDX_SIX_SLEEP = 16'h4079;
  localparam logic [15:0] LSC_IDX_SEVEN_CTL = 16'h407a;
  localparam logic [15:0] LSC_IDX_SEVEN_ON = 16'h407b;
  localparam logic [15:0] LSC_IDX_IRQ_STATUS = 16'h4080;
  localparam logic [15:0] LSC_IDX_IRQ_MASK = 16'h4081;
  localparam logic [15:0] LSC_IDX_STATE = 16'h4082;
  localparam int LSC_SLOT_LO = 13;
  localparam int LSC_MODE_BIT = 8;
  localparam int LSC_UVA_LO = 14;
  localparam int LSC_SRC_LO = 11;
  localparam int LSC_HVSEL_BIT = 10;
  localparam int LSC_HMODE_LO = 8;
  localparam int LSC_FLT_BIT = 7;
  localparam int LSC_SWI_BIT = 6;
  localparam logic [15:0] LSC_RST_SIX_SLEEP = 16'h0100;
  localparam logic [15:0] LSC_RST_SEVEN_CTL = 16'h0200;
  localparam logic [15:0] LSC_RST_SEVEN_ON = 16'h0000;
  localparam logic [15:0] LSC_WMASK_SLOT_REG = 16'he11f;
  localparam logic [15:0] LSC_WMASK_SEVEN_CTL = 16'hdfc0;
  localparam int LSC_IRQ_UV = 0;
  localparam int LSC_IRQ_SIX_DIS = 1;
  localparam int LSC_IRQ_SIX_SLP = 2;
  localparam logic [2:0] LSC_SLOT_HW1 = 3'h6;
  localparam logic [2:0] LSC_SLOT_HW2 = 3'h7;
  typedef enum logic [1:0] {LSC_UV_IGNORE, LSC_UV_SHUT_REG, LSC_UV_SHUT_SYS, LSC_UV_RSVD} lsc_uv_t;
  typedef enum logic [1:0] {LSC_HM_LP_A, LSC_HM_OFF, LSC_HM_LP_B, LSC_HM_ON_MODE} lsc_hmode_t;
  typedef enum logic [1:0] {LSC_SRC_NONE, LSC_SRC_ONE, LSC_SRC_TWO, LSC_SRC_EITHER} lsc_src_t;

  function automatic logic [LSC_ADDR_W-1:0] lsc_addr(input logic [15:0] idx);
    return {idx, 2'b00};
  endfunction : lsc_addr

  // Timeslot in which the sleep slot code acts.
  function automatic logic [2:0] lsc_sleep_slot(input logic [2:0] code);
    case (code)
      3'h0, 3'h1: return 3'h5;
      3'h2: return 3'h4;
      3'h3, 3'h6: return 3'h3;
      3'h4: return 3'h2;
      default: return 3'h1;
    endcase
  endfunction : lsc_sleep_slot

  function automatic logic lsc_is_disable(input logic [2:0] code);
    return (code != 3'h0) && (code < LSC_SLOT_HW1);
  endfunction : lsc_is_disable
endpackage : lsc_pkg

// >>> logic/lsc_ctl_if.sv
// Interface joining the register bank to the regulator_seven evaluator.
// Assumes both ends sit in the same clock domain; it carries levels only.
`timescale 1ns/1ps
interface lsc_ctl_if;
  logic [15:0] seven_ctl;
  logic [15:0] seven_on;
  logic [4:0] seven_sleep_voltage;
  logic hwctl1;
  logic hwctl2;
  logic hwctl_active;
  logic [4:0] eff_voltage;
  logic eff_lowpower;
  logic eff_off;
  modport regs (output seven_ctl, seven_on, seven_sleep_voltage, hwctl1, hwctl2,
    input hwctl_active, eff_voltage, eff_lowpower, eff_off);
  modport eval (input seven_ctl, seven_on, seven_sleep_voltage, hwctl1, hwctl2,
    output hwctl_active, eff_voltage, eff_lowpower, eff_off);
endinterface : lsc_ctl_if

// >>> logic/lsc_seven_eval.sv
// Combinational choice of regulator_seven voltage and mode between on and hardware control.
// Assumes the register bank registers whatever this module produces.
`timescale 1ns/1ps
module lsc_seven_eval
  import lsc_pkg::*;
(
  lsc_ctl_if.eval ctl
);
  wire lsc_src_t src = lsc_src_t'(ctl.seven_ctl[LSC_SRC_LO +: 2]);
  wire lsc_hmode_t hmode = lsc_hmode_t'(ctl.seven_ctl[LSC_HMODE_LO +: 2]);
  wire hv_choice = ctl.seven_ctl[LSC_HVSEL_BIT];
  wire on_mode = ctl.seven_on[LSC_MODE_BIT];
  wire [4:0] on_voltage = ctl.seven_on[4:0];
  wire active;
  wire hw_lowpower;

  assign active = (src == LSC_SRC_ONE && ctl.hwctl1) ||
    (src == LSC_SRC_TWO && ctl.hwctl2) ||
    (src == LSC_SRC_EITHER && (ctl.hwctl1 || ctl.hwctl2));
  assign hw_lowpower = (hmode == LSC_HM_ON_MODE) ? on_mode : (hmode != LSC_HM_OFF);
  assign ctl.hwctl_active = active;
  assign ctl.eff_voltage = (active && hv_choice) ? ctl.seven_sleep_voltage : on_voltage;
  assign ctl.eff_lowpower = active ? hw_lowpower : on_mode;
  assign ctl.eff_off = active && (hmode == LSC_HM_OFF);
endmodule : lsc_seven_eval

// >>> sim/lsc_slot_regs_tb.sv
// Self-checking bench for the regulator slot control register bank.
// Assumes the slave answers within 40 cycles and a one clock lag from inputs to outputs.
`timescale 1ns/1ps
module lsc_slot_regs_tb
  import lsc_pkg::*;
;
  typedef struct {
    logic [15:0] idx;
    logic [31:0] wd;
    logic [31:0] exp;
    logic err;
  } lsc_row_t;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [LSC_ADDR_W-1:0] paddr = '0;
  logic [LSC_DATA_W-1:0] pwdata = '0;
  logic [3:0] pstrb = 4'hf;
  logic seq_sleep = 1'b0;
  logic seq_strobe = 1'b0;
  logic [2:0] seq_slot = 3'h1;
  logic six_hw = 1'b0;
  logic hwen1 = 1'b0;
  logic hwen2 = 1'b0;
  logic hwc1 = 1'b0;
  logic hwc2 = 1'b0;
  logic [4:0] seven_slp_v = 5'h1c;
  logic uv = 1'b0;
  logic [LSC_DATA_W-1:0] prdata;
  logic pready, pslverr, irq, six_dis, six_state, six_lp, seven_en, seven_lp;
  logic seven_flt, seven_swi, seven_hwa, seven_uvsd, sys_rst;
  logic [4:0] six_v, seven_v;
  logic [31:0] rd;
  logic err;
  int n_mismatch = 0;
  int n_compared = 0;
  int cycles = 0;
  logic [2:0] slp_slot[8] = '{3'h5, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h3, 3'h1};
  lsc_row_t rows[8] = '{
    '{LSC_IDX_STATE, 32'hffffffff, 32'h0, 1'b0},
    '{LSC_IDX_SIX_SLEEP, 32'hffffffff, 32'he11f, 1'b0},
    '{LSC_IDX_SEVEN_CTL, 32'hffffffff, 32'hdfc0, 1'b0},
    '{LSC_IDX_SEVEN_ON, 32'hffffffff, 32'he11f, 1'b0},
    '{LSC_IDX_IRQ_MASK, 32'hffffffff, 32'h7, 1'b0},
    '{LSC_IDX_IRQ_MASK, 32'h0, 32'h0, 1'b0},
    '{16'h4083, 32'hffffffff, 32'h0, 1'b1},
    '{LSC_IDX_SEVEN_ON, 32'h0, 32'h0, 1'b0}
  };

  lsc_slot_regs dut_u (
    .CLK_IN(clk), .RESETN_IN(rstn), .PSEL_IN(psel), .PENABLE_IN(penable),
    .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PSTRB_IN(pstrb),
    .PREADY_OUT(pready), .PRDATA_OUT(prdata), .PSLVERR_OUT(pslverr),
    .SEQ_SLEEP_IN(seq_sleep), .SEQ_SLOT_STROBE_IN(seq_strobe), .SEQ_SLOT_IN(seq_slot),
    .SIX_HW_ASSIGNED_IN(six_hw), .HW_ENABLE1_IN(hwen1), .HW_ENABLE2_IN(hwen2),
    .HWCTL1_IN(hwc1), .HWCTL2_IN(hwc2), .SEVEN_SLEEP_VOLTAGE_IN(seven_slp_v),
    .SEVEN_UNDERVOLT_IN(uv), .IRQ_OUT(irq), .SIX_SLEEP_DISABLE_OUT(six_dis),
    .SIX_SLEEP_STATE_OUT(six_state), .SIX_SLEEP_VOLTAGE_OUT(six_v),
    .SIX_SLEEP_LOWPOWER_OUT(six_lp), .SEVEN_ENABLE_OUT(seven_en),
    .SEVEN_VOLTAGE_OUT(seven_v), .SEVEN_LOWPOWER_OUT(seven_lp),
    .SEVEN_FLOAT_OUT(seven_flt), .SEVEN_SWITCH_OUT(seven_swi),
    .SEVEN_HWCTL_ACTIVE_OUT(seven_hwa), .SEVEN_UV_SHUTDOWN_OUT(seven_uvsd),
    .SYS_RESET_REQ_OUT(sys_rst)
  );

  initial forever #2 clk = ~clk;

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      summarize();
    end
  end

  task automatic summarize();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One transfer; the request is held until pready is sampled high.
  task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 40) n_mismatch++;
  endtask : apb

  task automatic rdchk(input logic [15:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(rd, exp);
  endtask : rdchk

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  task automatic do_reset();
    @(posedge clk);
    rstn <= 1'b0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    #1;
    chk({six_lp, six_dis, seven_en, irq, sys_rst}, 5'h10);
    rdchk(LSC_IDX_SIX_SLEEP, 32'h0100);
    rdchk(LSC_IDX_SEVEN_CTL, 32'h0200);
    rdchk(LSC_IDX_SEVEN_ON, 32'h0000);
    rdchk(LSC_IDX_IRQ_STATUS, 32'h0);
  endtask : do_reset

  // Strobes a non-matching slot, then the given one.
  task automatic pair(input logic [2:0] slot);
    @(posedge clk);
    seq_strobe <= 1'b1;
    seq_slot <= (slot == 3'h5) ? 3'h1 : slot + 3'h1;
    @(posedge clk);
    seq_slot <= slot;
    #1;
    chk({six_dis, six_state, seven_en}, 3'h0);
    @(posedge clk);
    seq_strobe <= 1'b0;
    #1;
  endtask : pair

  initial begin
    logic [2:0] cd;
    logic [1:0] s, hc;
    logic dis, act, vs;
    int cnt;
    do_reset();
    foreach (rows[i]) begin
      apb(1'b1, rows[i].idx, rows[i].wd);
      chk(err, rows[i].err);
      apb(1'b0, rows[i].idx, 32'h0);
      chk({err, rd}, {rows[i].err, rows[i].exp});
    end
    for (int h = 0; h < 2; h++) begin
      for (int c = 0; c < 8; c++) begin
        cd = c[2:0];
        dis = (h == 0) && (c >= 1) && (c <= 5);
        apb(1'b1, LSC_IDX_SIX_SLEEP, {16'h0, cd, 4'h0, cd[0], 3'h0, 2'b10, cd});
        @(posedge clk);
        six_hw <= h[0];
        seq_sleep <= 1'b1;
        step(2);
        pair(slp_slot[c]);
        chk({six_dis, six_state}, {dis, !dis});
        chk(six_v, {2'b10, cd});
        chk(six_lp, cd[0]);
        @(posedge clk);
        seq_sleep <= 1'b0;
        step(2);
        chk({six_dis, six_state}, 2'b00);
      end
    end
    for (int c = 1; c < 6; c++) begin
      cd = c[2:0];
      apb(1'b1, LSC_IDX_SEVEN_ON, {16'h0, cd, 4'h0, cd[0], 3'h0, 2'b01, cd});
      pair(cd);
      chk(seven_en, 1'b1);
      chk(seven_v, {2'b01, cd});
      chk(seven_lp, cd[0]);
      @(posedge clk);
      seq_sleep <= 1'b1;
      step(2);
      chk(seven_en, 1'b0);
      @(posedge clk);
      seq_sleep <= 1'b0;
    end
    for (int k = 0; k < 8; k++) begin
      apb(1'b1, LSC_IDX_SEVEN_ON, {16'h0, 2'b11, k[2], 13'h0});
      @(posedge clk);
      hwen1 <= k[0];
      hwen2 <= k[1];
      step(2);
      chk(seven_en, k[2] ? k[1] : k[0]);
    end
    apb(1'b1, LSC_IDX_SEVEN_ON, {16'h0, 3'h6, 8'h0, 5'h03});
    @(posedge clk);
    hwen1 <= 1'b1;
    for (int k = 0; k < 16; k++) begin
      s = k[3:2];
      hc = k[1:0];
      vs = hc[0] ^ s[1];
      act = (s[0] && hc[0]) || (s[1] && hc[1]);
      apb(1'b1, LSC_IDX_SEVEN_CTL, {16'h0, 3'h0, s, vs, hc, s[0], hc[1], 6'h0});
      @(posedge clk);
      hwc1 <= hc[0];
      hwc2 <= hc[1];
      step(2);
      chk(seven_hwa, act);
      chk(seven_v, (act && vs) ? seven_slp_v : 5'h03);
      chk(seven_en, !(act && hc == 2'b01));
      if (!(act && hc == 2'b01)) chk(seven_lp, act && hc != 2'b11);
      chk({seven_flt, seven_swi}, {s[0], hc[1]});
    end
    rdchk(LSC_IDX_IRQ_STATUS, 32'h6);
    apb(1'b1, LSC_IDX_IRQ_STATUS, 32'h7);
    for (int a = 0; a < 4; a++) begin
      apb(1'b1, LSC_IDX_SEVEN_CTL, {16'h0, a[1:0], 14'h0});
      apb(1'b1, LSC_IDX_IRQ_MASK, {31'h0, a != 0});
      @(posedge clk);
      uv <= 1'b1;
      cnt = 0;
      repeat (4) begin
        @(posedge clk);
        uv <= 1'b0;
        #1;
        cnt += sys_rst;
      end
      chk(cnt, a == 2);
      chk(seven_uvsd, a == 1);
      chk({seven_en, irq}, {a != 1, a != 0});
      rdchk(LSC_IDX_IRQ_STATUS, 32'h1);
      apb(1'b1, LSC_IDX_IRQ_STATUS, 32'h1);
      step(2);
      chk({seven_uvsd, irq}, 2'b00);
    end
    apb(1'b1, LSC_IDX_SEVEN_ON, {16'h0, 3'h3, 13'h0});
    pair(3'h3);
    rdchk(LSC_IDX_STATE, 32'h9);
    apb(1'b1, LSC_IDX_SEVEN_ON, 32'h0);
    pair(3'h0);
    chk(seven_en, 1'b0);
    do_reset();
    pstrb <= 4'h1;
    apb(1'b1, LSC_IDX_SIX_SLEEP, 32'hffffffff);
    rdchk(LSC_IDX_SIX_SLEEP, 32'h011f);
    pstrb <= 4'h2;
    apb(1'b1, LSC_IDX_SIX_SLEEP, 32'h0);
    rdchk(LSC_IDX_SIX_SLEEP, 32'h001f);
    summarize();
  end
endmodule : lsc_slot_regs_tb
